// File: logic/sli_status_led.sv
// Contract
// - Drive three bi-colour health, network, I/O indicators
// - Health flashes green while unconfigured
// - Health steady green after clean initialization
// - Health flashes red on invalid parameter/slot data
// - Health steady red on hardware failure
// - Network off without an IP address
// - Network flashes green unconnected, green connected
// - Network flashes red on connection timeout
// - Network steady red on duplicate IP
// - I/O off when inactive or blocked
// - I/O steady green in normal run
// - I/O flashes green during firmware update
// - I/O flashes red on channel fault
// - Act as beacon-based ring node
// - Ring fault triggers forwarding flush and relearn
// - Report ring fault location to supervisor
`timescale 1ns/100ps
`default_nettype none
module sli_status_led
	import sli_pkg::*;
#(
	parameter int unsigned FLASH_CYC  = FLASH_HALF_CYC,
	parameter int unsigned BEACON_CYC = BEACON_TMO_CYC,
	parameter int unsigned NPORTS     = RING_PORTS
)(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// Adapter status
	input  wire sli_status_t status,
	// Ring node
	input  wire logic        ring_enable,
	input  wire logic [NPORTS-1:0] beacon_rx,
	// Indicators
	output sli_led_t         led_health_q,
	output sli_led_t         led_net_q,
	output sli_led_t         led_io_q,
	// Ring actions
	output logic             ring_fault_q,
	output logic             fdb_flush_q,
	output logic             fault_report_q,
	output logic [NPORTS-1:0] fault_port_q
);

	localparam int unsigned TW = $clog2(BEACON_CYC + 1);

	generate
		if (BEACON_CYC < 2 || NPORTS < 1)
		begin : g_bad
			$error("sli_status_led: BEACON_CYC >= 2 and NPORTS >= 1 required");
		end
	endgenerate

	// Indicator pattern for a state and flash phase
	function automatic sli_led_t show_drive(input sli_show_t s, input logic ph);
		sli_led_t d;
		d = LED_DARK;
		case (s)
			SHOW_OFF:       d = LED_DARK;
			SHOW_FLASH_GRN: d.grn = ph;
			SHOW_GRN:       d.grn = 1'b1;
			SHOW_FLASH_RED: d.red = ph;
			SHOW_RED:       d.red = 1'b1;
			default:        d = LED_DARK;
		endcase
		return d;
	endfunction

	logic      flash_tick;
	logic      phase_q;
	sli_show_t health_d;
	sli_show_t net_d;
	sli_show_t io_d;

	sli_tick_gen #(
		.PERIOD (FLASH_CYC)
	) u_flash (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.tick_q  (flash_tick)
	);

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			phase_q <= 1'b0;
		else if (flash_tick)
			phase_q <= ~phase_q;
	end

	always_comb
	begin
		if (status.hw_fail)
			health_d = SHOW_RED;
		else if (!status.configured)
			health_d = SHOW_FLASH_GRN;
		else if (status.param_invalid || status.slot_invalid)
			health_d = SHOW_FLASH_RED;
		else if (status.init_done)
			health_d = SHOW_GRN;
		else
			health_d = SHOW_FLASH_GRN;
	end

	always_comb
	begin
		if (status.dup_ip)
			net_d = SHOW_RED;
		else if (!status.ip_assigned)
			net_d = SHOW_OFF;
		else if (status.conn_timeout)
			net_d = SHOW_FLASH_RED;
		else if (status.conn_up)
			net_d = SHOW_GRN;
		else
			net_d = SHOW_FLASH_GRN;
	end

	always_comb
	begin
		if (status.io_active && status.io_fault)
			io_d = SHOW_FLASH_RED;
		else if (status.fw_update)
			io_d = SHOW_FLASH_GRN;
		else if (status.io_active && status.conn_up && status.configured
			&& !status.param_invalid && !status.slot_invalid)
			io_d = SHOW_GRN;
		else
			io_d = SHOW_OFF;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			led_health_q <= LED_DARK;
			led_net_q    <= LED_DARK;
			led_io_q     <= LED_DARK;
		end
		else
		begin
			led_health_q <= show_drive(health_d, phase_q);
			led_net_q    <= show_drive(net_d, phase_q);
			led_io_q     <= show_drive(io_d, phase_q);
		end
	end

	logic [NPORTS-1:0] lost_q;
	logic              any_lost;

	genvar gp;
	generate
		for (gp = 0; gp < NPORTS; gp++)
		begin : g_port
			logic [TW-1:0] tmr_q;
			logic          lost_bit_q;

			always_ff @(posedge ref_clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					tmr_q        <= '0;
					lost_bit_q   <= 1'b0;
				end
				else if (!ring_enable || beacon_rx[gp])
				begin
					tmr_q        <= '0;
					lost_bit_q   <= 1'b0;
				end
				else if (tmr_q == TW'(BEACON_CYC - 1))
					lost_bit_q   <= 1'b1;
				else
					tmr_q        <= tmr_q + TW'(1);
			end

			assign lost_q[gp] = lost_bit_q;
		end
	endgenerate

	assign any_lost = |lost_q;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ring_fault_q <= 1'b0;
			fdb_flush_q  <= 1'b0;
		end
		else
		begin
			ring_fault_q <= any_lost;
			fdb_flush_q  <= any_lost ^ ring_fault_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fault_report_q <= 1'b0;
			fault_port_q   <= '0;
		end
		else
		begin
			fault_report_q <= any_lost && !ring_fault_q;
			if (any_lost && !ring_fault_q)
				fault_port_q <= lost_q;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	property p_hw_red;
		status.hw_fail ##1 status.hw_fail |=> led_health_q == 2'h1;
	endproperty
	a_hw_red: assert property (p_hw_red) else $error("health not red on hw fail");

	property p_health_grn;
		(status == $past(status)) && !status.hw_fail && status.configured
		&& !status.param_invalid && !status.slot_invalid && status.init_done
		|=> led_health_q == 2'h2;
	endproperty
	a_health_grn: assert property (p_health_grn) else $error("health not green");

	property p_health_cfgerr;
		!status.hw_fail && status.configured && status.param_invalid
		|=> !led_health_q.grn;
	endproperty
	a_health_cfgerr: assert property (p_health_cfgerr) else $error("cfg error shows green");

	property p_net_off;
		!status.dup_ip && !status.ip_assigned |=> led_net_q == LED_DARK;
	endproperty
	a_net_off: assert property (p_net_off) else $error("net lit without address");

	property p_net_dup;
		status.dup_ip |=> led_net_q == 2'h1;
	endproperty
	a_net_dup: assert property (p_net_dup) else $error("net not red on dup ip");

	property p_net_tmo;
		!status.dup_ip && status.ip_assigned && status.conn_timeout |=> !led_net_q.grn;
	endproperty
	a_net_tmo: assert property (p_net_tmo) else $error("net green on timeout");

	property p_io_fault;
		status.io_active && status.io_fault |=> !led_io_q.grn;
	endproperty
	a_io_fault: assert property (p_io_fault) else $error("io green on fault");

	property p_io_off;
		!status.io_active && !status.fw_update |=> led_io_q == LED_DARK;
	endproperty
	a_io_off: assert property (p_io_off) else $error("io lit while inactive");

	property p_phase;
		flash_tick |=> phase_q != $past(phase_q);
	endproperty
	a_phase: assert property (p_phase) else $error("flash phase stuck");

	property p_flush;
		$rose(ring_fault_q) |-> fdb_flush_q && fault_report_q;
	endproperty
	a_flush: assert property (p_flush) else $error("no flush or report on fault");

	property p_report_port;
		fault_report_q |-> fault_port_q != '0 ##0 ring_fault_q;
	endproperty
	a_report_port: assert property (p_report_port) else $error("fault report lacks port");

	property p_beacon_clear;
		ring_enable && (&beacon_rx) |=> !any_lost ##1 !ring_fault_q;
	endproperty
	a_beacon_clear: assert property (p_beacon_clear) else $error("beacons did not clear");

	c_ring_fault: cover property ($rose(ring_fault_q));
	c_net_flash:  cover property (led_net_q.grn ##[1:1000] !led_net_q.grn);
	c_io_flashr:  cover property (status.io_active && status.io_fault ##1 led_io_q.red);
	c_ring_heal:  cover property ($fell(ring_fault_q) && fdb_flush_q);

endmodule // sli_status_led
`default_nettype wire

// File: logic/sli_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
module sli_tick_gen
	import sli_pkg::*;
#(
	parameter int unsigned PERIOD = FLASH_HALF_CYC
)(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// Tick
	output logic      tick_q
);

	localparam int unsigned CW = $clog2(PERIOD);

	logic [CW-1:0] cnt_q;

	generate
		if (PERIOD < 2)
		begin : g_bad
			$error("sli_tick_gen: PERIOD must be at least 2");
		end
	endgenerate

	// Divide down to one pulse per period
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else if (cnt_q == CW'(PERIOD - 1))
		begin
			cnt_q  <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + CW'(1);
			tick_q <= 1'b0;
		end
	end

endmodule // sli_tick_gen
`default_nettype wire

// File: pkg/sli_pkg.sv
`default_nettype none
package sli_pkg;

	// System clock
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned CLK_PERIOD_NS = 25;

	// Flash half period and its cycle count
	localparam int unsigned FLASH_HALF_MS  = 500;
	localparam int unsigned FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;

	// Beacon loss time and its cycle count
	localparam int unsigned BEACON_TMO_US  = 2000;
	localparam int unsigned BEACON_TMO_CYC = (CLK_HZ / 1_000_000) * BEACON_TMO_US;

	// Ring ports
	localparam int unsigned RING_PORTS = 2;

	// Indicator drive
	typedef struct packed {
		logic grn;
		logic red;
	} sli_led_t;

	localparam sli_led_t LED_DARK = 2'h0;

	// Indicator display state
	typedef enum logic [2:0] {
		SHOW_OFF,
		SHOW_FLASH_GRN,
		SHOW_GRN,
		SHOW_FLASH_RED,
		SHOW_RED
	} sli_show_t;

	// Adapter status conditions, all levels
	typedef struct packed {
		logic configured;
		logic param_invalid;
		logic slot_invalid;
		logic hw_fail;
		logic init_done;
		logic ip_assigned;
		logic conn_up;
		logic conn_timeout;
		logic dup_ip;
		logic fw_update;
		logic io_active;
		logic io_fault;
	} sli_status_t;

endpackage
`default_nettype wire

// File: testbench/sli_led_panel.sv
`timescale 1ns/100ps
`default_nettype none
module sli_led_panel
	import sli_pkg::*;
(
	// Indicators
	input  wire sli_led_t led_health_q,
	input  wire sli_led_t led_net_q,
	input  wire sli_led_t led_io_q,
	// Viewer result
	output logic          mixed
);
	assign mixed = (&led_health_q) | (&led_net_q) | (&led_io_q);
endmodule // sli_led_panel
`default_nettype wire

// File: testbench/status_led_indicator_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module status_led_indicator_control_test
	import sli_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	sli_status_t status = '0;
	logic        ring_enable = 1'b0;
	logic [1:0]  beacon_rx = 2'h0;
	sli_led_t    leds[3];
	logic        ring_fault_q;
	logic        fdb_flush_q;
	logic        fault_report_q;
	logic        mixed;
	logic [1:0]  fault_port_q;
	logic [3:0]  g[3];
	logic [3:0]  r[3];
	logic [11:0] rv;
	sli_show_t   e;
	int          error_cnt = 0;
	int          compares = 0;
	int          flush_n = 0;
	int          rep_n = 0;

	initial forever #12.5 ref_clk = ~ref_clk;

	sli_status_led #(.FLASH_CYC(4), .BEACON_CYC(8), .NPORTS(2)) dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .status(status),
		.ring_enable(ring_enable), .beacon_rx(beacon_rx),
		.led_health_q(leds[0]), .led_net_q(leds[1]), .led_io_q(leds[2]),
		.ring_fault_q(ring_fault_q), .fdb_flush_q(fdb_flush_q),
		.fault_report_q(fault_report_q), .fault_port_q(fault_port_q));

	sli_led_panel panel (
		.led_health_q(leds[0]), .led_net_q(leds[1]), .led_io_q(leds[2]),
		.mixed(mixed));

	always @(posedge ref_clk)
	begin
		flush_n <= flush_n + int'(fdb_flush_q);
		rep_n <= rep_n + int'(fault_report_q);
	end

	task automatic check(input logic ok, input string msg);
		compares++;
		if (!ok)
		begin
			error_cnt++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	task automatic print_verdict;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic sli_show_t exp_show(input sli_status_t s, input int k);
		if (k == 0)
			return s.hw_fail ? SHOW_RED : !s.configured ? SHOW_FLASH_GRN :
				(s.param_invalid | s.slot_invalid) ? SHOW_FLASH_RED :
				s.init_done ? SHOW_GRN : SHOW_FLASH_GRN;
		if (k == 1)
			return s.dup_ip ? SHOW_RED : !s.ip_assigned ? SHOW_OFF :
				s.conn_timeout ? SHOW_FLASH_RED : s.conn_up ? SHOW_GRN : SHOW_FLASH_GRN;
		return (s.io_active & s.io_fault) ? SHOW_FLASH_RED : s.fw_update ? SHOW_FLASH_GRN :
			(s.io_active & s.conn_up & s.configured & !s.param_invalid & !s.slot_invalid) ?
			SHOW_GRN : SHOW_OFF;
	endfunction

	function automatic logic [3:0] lit(input sli_show_t x, input sli_show_t st,
		input sli_show_t fl);
		return (x == st) ? 4'h8 : (x == fl) ? 4'h4 : 4'h0;
	endfunction

	task automatic show(input sli_status_t s);
		@(negedge ref_clk) status = s;
		repeat (2) @(negedge ref_clk);
		for (int k = 0; k < 3; k++)
		begin
			g[k] = 4'h0;
			r[k] = 4'h0;
		end
		repeat (8)
		begin
			@(negedge ref_clk);
			for (int k = 0; k < 3; k++)
			begin
				g[k] = g[k] + leds[k].grn;
				r[k] = r[k] + leds[k].red;
			end
			check(mixed === 1'b0, "two colours lit");
		end
		for (int k = 0; k < 3; k++)
		begin
			e = exp_show(s, k);
			check(g[k] === lit(e, SHOW_GRN, SHOW_FLASH_GRN), "green");
			check(r[k] === lit(e, SHOW_RED, SHOW_FLASH_RED), "red");
		end
	endtask

	task automatic beat(input logic [1:0] b);
		@(negedge ref_clk) beacon_rx = b;
		@(negedge ref_clk) beacon_rx = 2'h0;
		repeat (2) @(negedge ref_clk);
	endtask

	initial
	begin
		#125000;
		error_cnt++;
		print_verdict;
	end

	initial
	begin
		sli_status_t cc[5] = '{12'hfff, 12'h000, 12'h8e2, 12'hc54, 12'h840};
		void'($urandom(89));
		repeat (12) @(negedge ref_clk);
		rst_b = 1'b1;
		foreach (cc[i])
			show(cc[i]);
		repeat (60)
		begin
			rv = 12'($urandom);
			show(rv);
		end
		@(negedge ref_clk) ring_enable = 1'b1;
		repeat (6) beat(2'h3);
		check(ring_fault_q === 1'b0, "false ring fault");
		repeat (4) beat(2'h1);
		check(ring_fault_q === 1'b1, "no ring fault");
		check(fault_port_q === 2'h2, "fault port");
		check(rep_n == 1 && flush_n == 1, "report or flush count");
		repeat (2) beat(2'h3);
		check(ring_fault_q === 1'b0, "fault stuck");
		check(flush_n == 2, "relearn flush");
		@(negedge ref_clk) ring_enable = 1'b0;
		repeat (5) beat(2'h0);
		check(ring_fault_q === 1'b0 && rep_n == 1, "fault while disabled");
		print_verdict;
	end
endmodule // status_led_indicator_control_test
`default_nettype wire
